// File: src/flash_op_status_register.sv
// status register of the banked program/erase controller
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - snapshot on strobe fall, hold while low
// - reads in any bank return status unless array mode selected
// - status bits follow operation state automatically
// - error bits sticky until clear or reset
// - ready low while controller active anywhere
// - ready stays low until suspend takes effect
// - erase suspended set on pause, cleared resume
// - finishing within latency leaves suspend low
// - erase verify failure sets erase error
// - blank check non-FFFF word sets erase error
// - stale erase error fails new erase
// - locked block target aborts, sets protect error unless vpp low
// - program suspended only while program paused
// - bank write encodes busy bank location
// - factory mode bank write shows buffer readiness
// - program verify fault, or overwrite fault at high vpp, sets error
// - low vpp at start sets error, aborts
module flash_op_status_register #(
  parameter int unsigned DATA_W = 16
) (
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              chip_en_b,
  input  wire logic              out_en_b,
  input  wire logic              read_array_mode,
  input  wire logic              addr_in_busy_bank,
  input  wire logic              array_read_valid,
  input  wire logic [DATA_W-1:0] array_rdata,
  input  wire logic              ctrl_active,
  input  wire logic              op_is_erase,
  input  wire logic              op_start,
  input  wire logic              op_paused,
  input  wire logic              resume_cmd,
  input  wire logic              clear_status_cmd,
  input  wire logic              erase_verify_fail,
  input  wire logic              blank_check_word_valid,
  input  wire logic [DATA_W-1:0] blank_check_word,
  input  wire logic              program_verify_fail,
  input  wire logic              program_one_over_zero,
  input  wire logic              vpp_high,
  input  wire logic              vpp_below_lockout,
  input  wire logic              target_locked,
  input  wire logic              factory_mode,
  input  wire logic              factory_buffer_ready,
  input  wire logic              factory_exited,
  output logic                   op_abort,
  output logic                   read_is_status,
  output logic [DATA_W-1:0]      read_data_q
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (DATA_W < op_status_pkg::STATUS_W) begin : g_bad_width
    $error("data bus narrower than status byte");
  end
  // the blank check compares against one erased word, so the bus must match it
  if (DATA_W != $bits(op_status_pkg::ERASED_WORD)) begin : g_bad_blank
    $error("data bus width differs from the erased word");
  end

  // ----------------------------------------------------------------
  // strobe synchronisers: pins come from outside the clock domain
  // ----------------------------------------------------------------
  logic [1:0] strobe_meta_q;
  logic [1:0] strobe_sync_q;
  logic [1:0] strobe_prev_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_meta_q <= op_status_pkg::STROBE_IDLE;
      strobe_sync_q <= op_status_pkg::STROBE_IDLE;
      strobe_prev_q <= op_status_pkg::STROBE_IDLE;
    end else begin
      strobe_meta_q <= {chip_en_b, out_en_b};
      strobe_sync_q <= strobe_meta_q;
      strobe_prev_q <= strobe_sync_q;
    end
  end
  logic strobe_fall;
  logic strobes_low;
  assign strobe_fall = |(strobe_prev_q & ~strobe_sync_q);
  assign strobes_low = ~|strobe_sync_q;

  // ----------------------------------------------------------------
  // sticky error flags
  // ----------------------------------------------------------------
  logic erase_err_q;
  logic prog_err_q;
  logic vpp_err_q;
  logic prot_err_q;
  logic any_err;
  logic set_erase;
  logic set_prog;
  logic set_vpp;
  logic set_prot;
  logic blank_bad;
  assign any_err = erase_err_q | prog_err_q | vpp_err_q | prot_err_q;
  // the vpp lockout level is looked at only when an operation starts
  assign set_vpp  = op_start & vpp_below_lockout;
  // a vpp fault blocks the start, so the lock state is not reported then
  assign set_prot = op_start & target_locked & ~vpp_below_lockout;
  // a leftover error makes the new operation fail outright
  assign op_abort = op_start & (vpp_below_lockout | target_locked | any_err);
  assign blank_bad = blank_check_word_valid
                   & (blank_check_word != op_status_pkg::ERASED_WORD);
  // erase and blank check share one error flag
  assign set_erase = erase_verify_fail | blank_bad
                   | (op_start & op_is_erase & erase_err_q);
  // overwrite fault only counts at high vpp
  assign set_prog = program_verify_fail | (program_one_over_zero & vpp_high);

  sticky_flag u_erase_err (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .set_ev   (set_erase),
    .clr_ev   (clear_status_cmd),
    .flag_q   (erase_err_q)
  );
  sticky_flag u_prog_err (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .set_ev   (set_prog),
    .clr_ev   (clear_status_cmd),
    .flag_q   (prog_err_q)
  );
  sticky_flag u_vpp_err (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .set_ev   (set_vpp),
    .clr_ev   (clear_status_cmd),
    .flag_q   (vpp_err_q)
  );
  sticky_flag u_prot_err (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .set_ev   (set_prot),
    .clr_ev   (clear_status_cmd),
    .flag_q   (prot_err_q)
  );

  // ----------------------------------------------------------------
  // suspend state, driven only by controller events
  // ----------------------------------------------------------------
  // resume clears both kinds; the controller only ever pauses one at a time
  logic erase_susp_q;
  logic prog_susp_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      erase_susp_q <= 1'b0;
    end else if (resume_cmd) begin
      erase_susp_q <= 1'b0;
    end else if (op_paused && op_is_erase) begin
      // a finished operation never raises op_paused, so the flag stays low
      erase_susp_q <= 1'b1;
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prog_susp_q <= 1'b0;
    end else if (resume_cmd) begin
      prog_susp_q <= 1'b0;
    end else if (op_paused && !op_is_erase) begin
      prog_susp_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // live status byte
  // ----------------------------------------------------------------
  logic ready;
  logic bank_write;
  // ctrl_active stays high after a suspend until the pause is reached
  assign ready = ~ctrl_active;
  // the factory exit indication is the only case where idle shows the bit set
  always_comb begin
    if (factory_mode) begin
      bank_write = ctrl_active ? ~factory_buffer_ready : factory_exited;
    end else begin
      // idle with the bit set is never produced
      bank_write = ctrl_active & ~addr_in_busy_bank;
    end
  end
  logic [op_status_pkg::STATUS_W-1:0] status_live;
  always_comb begin
    status_live = '0;
    status_live[op_status_pkg::BIT_READY]      = ready;
    status_live[op_status_pkg::BIT_ERASE_SUSP] = erase_susp_q;
    status_live[op_status_pkg::BIT_ERASE_ERR]  = erase_err_q;
    status_live[op_status_pkg::BIT_PROG_ERR]   = prog_err_q;
    status_live[op_status_pkg::BIT_VPP_ERR]    = vpp_err_q;
    status_live[op_status_pkg::BIT_PROG_SUSP]  = prog_susp_q;
    status_live[op_status_pkg::BIT_PROT_ERR]   = prot_err_q;
    status_live[op_status_pkg::BIT_BANK_WRITE] = bank_write;
  end

  // ----------------------------------------------------------------
  // read path: status snapshot held for the whole strobe-low window; array data reloads on each valid low cycle
  // ----------------------------------------------------------------
  // status mode stays in force while idle so the host can poll for ready,
  // and a busy bank returns status on every address until array mode is chosen
  assign read_is_status = ~read_array_mode;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      read_data_q <= {{(DATA_W-op_status_pkg::STATUS_W){1'b0}}, op_status_pkg::STATUS_RESET};
    end else if (read_is_status) begin
      if (strobe_fall) begin
        // snapshot rather than live value so the host sees a stable word
        read_data_q <= {{(DATA_W-op_status_pkg::STATUS_W){1'b0}}, status_live};
      end
    end else if (array_read_valid && strobes_low) begin
      read_data_q <= array_rdata;
    end
  end
endmodule
`default_nettype wire

// File: src/op_status_pkg.sv
// constants for the flash operation status register
package op_status_pkg;
  // ----------------------------------------------------------------
  // bit positions of the status byte
  // ----------------------------------------------------------------
  localparam int unsigned BIT_READY       = 7;
  localparam int unsigned BIT_ERASE_SUSP  = 6;
  localparam int unsigned BIT_ERASE_ERR   = 5;
  localparam int unsigned BIT_PROG_ERR    = 4;
  localparam int unsigned BIT_VPP_ERR     = 3;
  localparam int unsigned BIT_PROG_SUSP   = 2;
  localparam int unsigned BIT_PROT_ERR    = 1;
  localparam int unsigned BIT_BANK_WRITE  = 0;
  localparam int unsigned STATUS_W        = 8;
  // ----------------------------------------------------------------
  // values after reset and the erased word
  // ----------------------------------------------------------------
  localparam logic [7:0]  STATUS_RESET    = 8'h80;
  localparam logic [15:0] ERASED_WORD     = 16'hFFFF;
  localparam logic [1:0]  STROBE_IDLE     = 2'h3;
endpackage

// File: src/sticky_flag.sv
// one sticky error flag: set by hardware, cleared by command or reset
`timescale 1ns/1ps
`default_nettype none
module sticky_flag (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic set_ev,
  input  wire logic clr_ev,
  output var  logic flag_q
);
  // set wins over a clear in the same cycle so no error is lost
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= 1'b0;
    end else if (set_ev) begin
      flag_q <= 1'b1;
    end else if (clr_ev) begin
      flag_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: verification/flash_op_status_chk.sv
// port assertions for the status register
`timescale 1ns/1ps
`default_nettype none
module flash_op_status_chk #(parameter int unsigned DATA_W = 16) (
  input wire logic              core_clk,
  input wire logic              rst_b,
  input wire logic              chip_en_b,
  input wire logic              out_en_b,
  input wire logic              read_array_mode,
  input wire logic              addr_in_busy_bank,
  input wire logic              ctrl_active,
  input wire logic              op_start,
  input wire logic              vpp_below_lockout,
  input wire logic              target_locked,
  input wire logic              factory_mode,
  input wire logic              op_abort,
  input wire logic              read_is_status,
  input wire logic [DATA_W-1:0] read_data_q
);
  // ----
  // checks
  // ----
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic rd_lo;
  // five low cycles put us past the synchroniser, so the snapshot is settled
  assign rd_lo = !chip_en_b && !out_en_b && read_is_status;
  a_abort_vpp: assert property (op_start && vpp_below_lockout |-> op_abort)
    else $error("no abort on low vpp");
  a_abort_lock: assert property (op_start && target_locked |-> op_abort)
    else $error("no abort on locked block");
  a_abort_cause: assert property (op_abort |-> op_start)
    else $error("abort without start");
  a_status_path: assert property (ctrl_active && addr_in_busy_bank && !read_array_mode
    |-> read_is_status)
    else $error("busy bank read not status");
  a_snap_hold: assert property (rd_lo [*5] |-> $stable(read_data_q))
    else $error("snapshot moved while strobes low");
  a_upper_zero: assert property (rd_lo [*5] |-> read_data_q[DATA_W-1:8] == '0)
    else $error("upper data lines not zero");
  a_ready_low: assert property ((rd_lo && ctrl_active) [*6] |-> !read_data_q[7])
    else $error("ready set while busy");
  a_bank_local: assert property ((rd_lo && ctrl_active && addr_in_busy_bank && !factory_mode) [*6]
    |-> !read_data_q[0])
    else $error("bank write wrong for busy bank");
  a_ready_high: assert property ((rd_lo && !ctrl_active) [*6] |-> read_data_q[7])
    else $error("ready clear while idle");
  a_bank_other: assert property ((rd_lo && ctrl_active && !addr_in_busy_bank && !factory_mode) [*6]
    |-> read_data_q[0])
    else $error("bank write wrong for other bank");
  c_abort: cover property (op_abort);
  c_idle: cover property (rd_lo && !ctrl_active);
  c_read: cover property (rd_lo [*5]);
  c_fact: cover property (rd_lo && factory_mode);
endmodule
`default_nettype wire

// File: verification/flash_host_model.sv
// host side: issues single-word reads on the strobes
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
  input wire logic core_clk,
  input wire logic rd_go,
  output var logic chip_en_b,
  output var logic out_en_b
);
  // one word per strobe pair, never a burst
  initial begin
    {chip_en_b, out_en_b} = 2'h3;
    forever begin
      @(posedge core_clk);
      if (rd_go) begin
        #1 {chip_en_b, out_en_b} = 2'h0;
        repeat (8) @(posedge core_clk);
        #1 {chip_en_b, out_en_b} = 2'h3;
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/flash_op_status_register_test.sv
// self-checking bench for the flash operation status register
`timescale 1ns/1ps
`default_nettype none
bind flash_op_status_register flash_op_status_chk #(.DATA_W(DATA_W)) i_flash_op_status_chk (
  .core_clk          (core_clk),
  .rst_b             (rst_b),
  .chip_en_b         (chip_en_b),
  .out_en_b          (out_en_b),
  .read_array_mode   (read_array_mode),
  .addr_in_busy_bank (addr_in_busy_bank),
  .ctrl_active       (ctrl_active),
  .op_start          (op_start),
  .vpp_below_lockout (vpp_below_lockout),
  .target_locked     (target_locked),
  .factory_mode      (factory_mode),
  .op_abort          (op_abort),
  .read_is_status    (read_is_status),
  .read_data_q       (read_data_q)
);
module flash_op_status_register_test;
  // ----
  // signals
  // ----
  logic core_clk, rst_b, chip_en_b, out_en_b, read_array_mode, addr_in_busy_bank, rd_go;
  logic array_read_valid, ctrl_active, op_is_erase, op_start, op_paused, resume_cmd, es, ps;
  logic clear_status_cmd, erase_verify_fail, blank_check_word_valid, program_verify_fail;
  logic program_one_over_zero, vpp_high, vpp_below_lockout, target_locked, factory_mode, vh;
  logic factory_buffer_ready, factory_exited, op_abort, read_is_status;
  logic [15:0] array_rdata, blank_check_word, read_data_q;
  logic [3:0]  err;
  logic [31:0] r;
  logic [31:0] corner [5] = '{32'h0000_9001, 32'h0000_2240, 32'h0000_0030, 32'h0000_9000,
                              32'h1234_0010};
  int          miscompares = 0, cmp_count = 0, cyc = 0;
  flash_op_status_register #(.DATA_W(16)) i_flash_op_status_register (
    .core_clk               (core_clk),
    .rst_b                  (rst_b),
    .chip_en_b              (chip_en_b),
    .out_en_b               (out_en_b),
    .read_array_mode        (read_array_mode),
    .addr_in_busy_bank      (addr_in_busy_bank),
    .array_read_valid       (array_read_valid),
    .array_rdata            (array_rdata),
    .ctrl_active            (ctrl_active),
    .op_is_erase            (op_is_erase),
    .op_start               (op_start),
    .op_paused              (op_paused),
    .resume_cmd             (resume_cmd),
    .clear_status_cmd       (clear_status_cmd),
    .erase_verify_fail      (erase_verify_fail),
    .blank_check_word_valid (blank_check_word_valid),
    .blank_check_word       (blank_check_word),
    .program_verify_fail    (program_verify_fail),
    .program_one_over_zero  (program_one_over_zero),
    .vpp_high               (vpp_high),
    .vpp_below_lockout      (vpp_below_lockout),
    .target_locked          (target_locked),
    .factory_mode           (factory_mode),
    .factory_buffer_ready   (factory_buffer_ready),
    .factory_exited         (factory_exited),
    .op_abort               (op_abort),
    .read_is_status         (read_is_status),
    .read_data_q            (read_data_q)
  );
  flash_host_model i_flash_host_model (
    .core_clk  (core_clk),
    .rd_go     (rd_go),
    .chip_en_b (chip_en_b),
    .out_en_b  (out_en_b)
  );
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // generous ceiling: the run needs about a fifth of it
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bank write: busy bank 0, other bank 1, factory mode shows buffer readiness or exit
  function automatic logic [15:0] exp_st();
    logic bw;
    bw = factory_mode ? (ctrl_active ? ~factory_buffer_ready : factory_exited)
                      : (ctrl_active & ~addr_in_busy_bank);
    return {8'h00, ~ctrl_active, es, err[3:1], ps, err[0], bw};
  endfunction
  // the gap at the end lets the host release the strobes before the next read
  task automatic rd(input logic arr, input logic [15:0] exp);
    read_array_mode = arr;
    rd_go = 1'b1;
    @(posedge core_clk);
    #1 rd_go = 1'b0;
    repeat (6) @(posedge core_clk);
    #1 chk(read_data_q, exp);
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  initial begin
    {read_array_mode, array_read_valid, op_is_erase, op_start, op_paused, resume_cmd, es, ps,
     clear_status_cmd, erase_verify_fail, blank_check_word_valid, program_verify_fail, vh,
     program_one_over_zero, vpp_high, vpp_below_lockout, target_locked, factory_mode, rd_go,
     factory_buffer_ready, factory_exited, rst_b, array_rdata, blank_check_word, err} = '0;
    {ctrl_active, addr_in_busy_bank} = 2'h3;
    void'($urandom(32'h1101));
    repeat (12) @(posedge core_clk);
    #1 chk(read_data_q, {8'h00, op_status_pkg::STATUS_RESET});
    rst_b = 1'b1;
    for (int i = 0; i < 40; i++) begin
      r = (i < 5) ? corner[i] : $urandom;
      {erase_verify_fail, program_verify_fail} = r[1:0];
      op_start = r[6] & r[13];
      program_one_over_zero = r[2] & ~op_start;
      if (op_start) vpp_high = r[3];
      blank_check_word_valid = r[4];
      blank_check_word = r[5] ? 16'hFFFF : r[31:16];
      {op_is_erase, target_locked, vpp_below_lockout} = r[9:7];
      op_paused = r[10] & r[14];
      resume_cmd = r[11] & ~op_paused;
      clear_status_cmd = (r[12] & r[15]) | ((|err) & r[22]);
      {factory_exited, factory_buffer_ready, factory_mode} = r[18:16];
      {ctrl_active, addr_in_busy_bank} = ~r[21:20];
      array_rdata = r[31:16];
      array_read_valid = 1'b1;
      #1 chk({15'h0, op_abort}, {15'h0, op_start & (r[7] | r[8] | (|err))});
      if (op_start) vh = vpp_high;
      err = {erase_verify_fail | (blank_check_word_valid & (blank_check_word != 16'hFFFF))
             | (op_start & op_is_erase & err[3]), program_verify_fail | (program_one_over_zero & vh),
             op_start & r[7], op_start & ~r[7] & r[8]} | (clear_status_cmd ? 4'h0 : err);
      if (op_paused) {es, ps} = {es | op_is_erase, ps | ~op_is_erase};
      if (resume_cmd) {es, ps} = 2'h0;
      @(posedge core_clk);
      #1 {erase_verify_fail, program_verify_fail, program_one_over_zero, op_start,
          blank_check_word_valid, op_paused, resume_cmd, clear_status_cmd} = '0;
      rd(1'b0, exp_st());
      if (!ctrl_active) chk({13'h0, read_data_q[7:5]}, {13'h0, 1'b1, es, err[3]});
      if (i % 4 == 3) rd(1'b1, array_rdata);
    end
    final_report();
  end
endmodule
`default_nettype wire
